/* verilog/dscg_pkg.sv */
// Constants, types and helpers for the deep-sleep clock gating block.
// Assumes a 32-bit register port with byte addresses.
`default_nettype none

package dscg_pkg;

  localparam int          DW          = 32;
  localparam int          ADDR_W_DEF  = 12;
  localparam int          UNIT_IDX_W  = 5;

  // Register byte offsets
  localparam logic [11:0] OFF_RUN_CFG    = 12'h060;
  localparam logic [11:0] OFF_RUN_GATE   = 12'h104;
  localparam logic [11:0] OFF_SLEEP_GATE = 12'h114;
  localparam logic [11:0] OFF_DEEP_GATE  = 12'h124;
  localparam logic [11:0] OFF_INT_STAT   = 12'h200;
  localparam logic [11:0] OFF_INT_MASK   = 12'h204;

  // Gate bit positions
  localparam int GP_TIMER_THREE_CLK_EN    = 19; // [R8]
  localparam int GP_TIMER_TWO_CLK_EN      = 18; // [R8]
  localparam int GP_TIMER_ONE_CLK_EN      = 17; // [R8]
  localparam int GP_TIMER_ZERO_CLK_EN     = 16; // [R8]
  localparam int TWO_WIRE_ZERO_CLK_EN     = 12; // [R9]
  localparam int SYNC_SERIAL_ZERO_CLK_EN  = 4;  // [R9]
  localparam int ENCODER_IF_ONE_CLK_EN    = 9;  // [R10]
  localparam int ENCODER_IF_ZERO_CLK_EN   = 8;  // [R10]
  localparam int ASYNC_SERIAL_ONE_CLK_EN  = 1;  // [R11]
  localparam int ASYNC_SERIAL_ZERO_CLK_EN = 0;  // [R11]
  localparam int COMPARATOR_ZERO_CLK_EN   = 24; // [R13]

  // Implemented gate bits; all others are reserved
  localparam logic [DW-1:0] GATE_IMPL  = 32'h010F_1313;
  localparam logic [DW-1:0] GATE_RESET = 32'h0000_0000;

  // Run-mode clock configuration
  localparam int            AUTO_CLOCK_GATING_SELECT = 27;
  localparam logic [DW-1:0] CFG_IMPL   = 32'h0800_0000;
  localparam logic [DW-1:0] CFG_RESET  = 32'h0000_0000;

  // Interrupt status layout
  localparam int            INT_W      = 4;
  localparam int            INT_FAULT  = 0;
  localparam int            INT_SLEEP  = 1;
  localparam int            INT_DEEP   = 2;
  localparam int            INT_RSVD   = 3;
  localparam logic [INT_W-1:0] INT_RESET = 4'h0;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } dscg_mode_e;

  function automatic logic [DW-1:0] gate_clean(input logic [DW-1:0] v);
    return v & GATE_IMPL;
  endfunction

  function automatic logic rsvd_touch(input logic [DW-1:0] v);
    return |(v & ~GATE_IMPL);
  endfunction

endpackage

`default_nettype wire

/* verilog/dscg_gate_if.sv */
// Interface between the gating register file and the access checker.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none

interface dscg_gate_if;
  import dscg_pkg::*;

  logic [DW-1:0]         unit_en;
  logic                  acc_req;
  logic [UNIT_IDX_W-1:0] acc_bit;
  logic                  fault;
  logic                  done;

  modport top (
    output unit_en,
    output acc_req,
    output acc_bit,
    input  fault,
    input  done
  );

  modport chk (
    input  unit_en,
    input  acc_req,
    input  acc_bit,
    output fault,
    output done
  );

endinterface

`default_nettype wire

/* verilog/dscg_fault_chk.sv */
// Access checker: answers peripheral accesses with fault or completion.
// Assumes one-cycle access requests on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module dscg_fault_chk (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  dscg_gate_if.chk  gi
);
  import dscg_pkg::*;

  logic unit_on;
  logic next_fault;
  logic next_done;

  assign unit_on    = gi.unit_en[gi.acc_bit];
  assign next_fault = gi.acc_req & ~unit_on; // [R4]
  assign next_done  = gi.acc_req & unit_on;  // [R2]

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gi.fault <= 1'b0;
      gi.done  <= 1'b0;
    end else begin
      gi.fault <= next_fault;
      gi.done  <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_fault_gated;
    @(posedge sys_clk) disable iff (!rst_n)
      gi.acc_req && !gi.unit_en[gi.acc_bit] |=> gi.fault && !gi.done;
  endproperty
  a_fault_gated: assert property (p_fault_gated) // [R4]
    else $error("gated unit access not faulted");

  property p_done_open;
    @(posedge sys_clk) disable iff (!rst_n)
      gi.acc_req && gi.unit_en[gi.acc_bit] |=> gi.done && !gi.fault;
  endproperty
  a_done_open: assert property (p_done_open) // [R2]
    else $error("enabled unit access not completed");

  property p_no_spurious;
    @(posedge sys_clk) disable iff (!rst_n)
      !gi.acc_req |=> !gi.fault && !gi.done;
  endproperty
  a_no_spurious: assert property (p_no_spurious) // [R4]
    else $error("answer without access");

endmodule

`default_nettype wire

/* verilog/dscg_top.sv */
// Deep-sleep clock gating register bank with run and sleep companions.
// Assumes a single-cycle register port and same-clock mode inputs.
//
// Behaviour
// [R1] Deep-sleep gate register at 0x124, read/write
// [R2] Each implemented bit enables one unit clock
// [R3] Clear bit stops clock, holds unit disabled
// [R4] Access to gated unit returns bus fault
// [R5] Reset clears the register to zero
// [R6] Run, sleep, deep registers; deep used in deep-sleep
// [R7] Sleep registers honoured only with auto gating set
// [R8] Timers three to zero on bits 19-16
// [R9] Two-wire bit 12, sync serial bit 4
// [R10] Encoder interfaces one, zero on bits 9, 8
// [R11] Async serial one, zero on bits 1, 0
// [R12] Reserved bits read-only, read as zero
// [R13] Comparator zero on bit 24
`timescale 1ns/1ps
`default_nettype none

module dscg_top #(
  parameter int ADDR_W = dscg_pkg::ADDR_W_DEF
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  input  wire logic [ADDR_W-1:0]               reg_addr,
  input  wire logic [dscg_pkg::DW-1:0]         reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output var  logic [dscg_pkg::DW-1:0]         reg_rdata,
  input  wire logic                            sys_sleep,
  input  wire logic                            sys_deep,
  input  wire logic                            acc_req,
  input  wire logic [dscg_pkg::UNIT_IDX_W-1:0] acc_bit,
  output var  logic                            acc_fault,
  output var  logic                            acc_done,
  output var  logic [dscg_pkg::DW-1:0]         unit_clk_en,
  output var  logic [dscg_pkg::DW-1:0]         unit_hold,
  output var  logic                            irq
);
  import dscg_pkg::*;

  if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_chk
    $error("ADDR_W must be 10 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unit bit map

  localparam logic [DW-1:0] UNIT_MAP =
    (DW'(1) << GP_TIMER_THREE_CLK_EN)    | // [R8]
    (DW'(1) << GP_TIMER_TWO_CLK_EN)      | // [R8]
    (DW'(1) << GP_TIMER_ONE_CLK_EN)      | // [R8]
    (DW'(1) << GP_TIMER_ZERO_CLK_EN)     | // [R8]
    (DW'(1) << TWO_WIRE_ZERO_CLK_EN)     | // [R9]
    (DW'(1) << SYNC_SERIAL_ZERO_CLK_EN)  | // [R9]
    (DW'(1) << ENCODER_IF_ONE_CLK_EN)    | // [R10]
    (DW'(1) << ENCODER_IF_ZERO_CLK_EN)   | // [R10]
    (DW'(1) << ASYNC_SERIAL_ONE_CLK_EN)  | // [R11]
    (DW'(1) << ASYNC_SERIAL_ZERO_CLK_EN) | // [R11]
    (DW'(1) << COMPARATOR_ZERO_CLK_EN);    // [R13]

  // Each unit owns one writable gate bit, the rest stay reserved
  if (UNIT_MAP != GATE_IMPL) begin : g_map_chk
    $error("gate bit map disagrees with implemented mask");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [DW-1:0]    run_gate;
  logic [DW-1:0]    sleep_gate;
  logic [DW-1:0]    deep_gate;
  logic [DW-1:0]    run_cfg;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;
  dscg_mode_e       mode_q;

  dscg_gate_if gi ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic hit_run_gate;
  logic hit_sleep_gate;
  logic hit_deep_gate;
  logic hit_run_cfg;
  logic hit_int_stat;
  logic hit_int_mask;
  logic hit_any_gate;

  assign hit_run_gate   = reg_addr == ADDR_W'(OFF_RUN_GATE);
  assign hit_sleep_gate = reg_addr == ADDR_W'(OFF_SLEEP_GATE);
  assign hit_deep_gate  = reg_addr == ADDR_W'(OFF_DEEP_GATE); // [R1]
  assign hit_run_cfg    = reg_addr == ADDR_W'(OFF_RUN_CFG);
  assign hit_int_stat   = reg_addr == ADDR_W'(OFF_INT_STAT);
  assign hit_int_mask   = reg_addr == ADDR_W'(OFF_INT_MASK);
  assign hit_any_gate   = hit_run_gate | hit_sleep_gate | hit_deep_gate;

  logic wr_run_gate;
  logic wr_sleep_gate;
  logic wr_deep_gate;
  logic wr_run_cfg;
  logic wr_int_mask;
  logic rd_int_stat;

  assign wr_run_gate   = reg_wr & hit_run_gate;
  assign wr_sleep_gate = reg_wr & hit_sleep_gate;
  assign wr_deep_gate  = reg_wr & hit_deep_gate; // [R1]
  assign wr_run_cfg    = reg_wr & hit_run_cfg;
  assign wr_int_mask   = reg_wr & hit_int_mask;
  assign rd_int_stat   = reg_rd & hit_int_stat;

  ////////////////////////////////////////////////////////////////////////////
  // Next register values

  logic [DW-1:0]    next_run_gate;
  logic [DW-1:0]    next_sleep_gate;
  logic [DW-1:0]    next_deep_gate;
  logic [DW-1:0]    next_run_cfg;
  logic [INT_W-1:0] next_int_mask;

  // Reserved bits are dropped on write
  assign next_run_gate   = wr_run_gate ? gate_clean(reg_wdata) : run_gate;
  assign next_sleep_gate = wr_sleep_gate ? gate_clean(reg_wdata)
                                         : sleep_gate;
  assign next_deep_gate  = wr_deep_gate ? gate_clean(reg_wdata) // [R12]
                                        : deep_gate;
  assign next_run_cfg    = wr_run_cfg ? (reg_wdata & CFG_IMPL) : run_cfg;
  assign next_int_mask   = wr_int_mask ? reg_wdata[INT_W-1:0] : int_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection

  logic          auto_gate_on;
  dscg_mode_e    mode;
  logic [DW-1:0] sel_gate;

  assign auto_gate_on = run_cfg[AUTO_CLOCK_GATING_SELECT];

  // Sleep registers only count when automatic gating is chosen
  assign mode = !auto_gate_on ? MODE_RUN :             // [R7]
                !sys_sleep    ? MODE_RUN :
                sys_deep      ? MODE_DEEP : MODE_SLEEP; // [R6]

  assign sel_gate = (mode == MODE_DEEP)  ? deep_gate :  // [R6]
                    (mode == MODE_SLEEP) ? sleep_gate : run_gate;

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt

  logic             ev_deep;
  logic             ev_sleep;
  logic             ev_rsvd;
  logic [INT_W-1:0] events;
  logic [INT_W-1:0] next_int_stat;

  assign ev_deep  = (mode == MODE_DEEP) && (mode_q != MODE_DEEP);
  assign ev_sleep = (mode == MODE_SLEEP) && (mode_q != MODE_SLEEP);
  assign ev_rsvd  = reg_wr & hit_any_gate & rsvd_touch(reg_wdata);

  always_comb begin
    events            = '0;
    events[INT_FAULT] = gi.fault;
    events[INT_SLEEP] = ev_sleep;
    events[INT_DEEP]  = ev_deep;
    events[INT_RSVD]  = ev_rsvd;
  end

  // A new event beats the read that clears the status
  assign next_int_stat = (rd_int_stat ? INT_RESET : int_stat) | events;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [DW-1:0] rd_mux;

  assign rd_mux = hit_run_gate   ? run_gate :
                  hit_sleep_gate ? sleep_gate :
                  hit_deep_gate  ? deep_gate :              // [R1]
                  hit_run_cfg    ? run_cfg :
                  hit_int_stat   ? DW'(int_stat) :
                  hit_int_mask   ? DW'(int_mask) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run_gate   <= GATE_RESET;
      sleep_gate <= GATE_RESET;
      deep_gate  <= GATE_RESET; // [R5]
      run_cfg    <= CFG_RESET;
    end else begin
      run_gate   <= next_run_gate;
      sleep_gate <= next_sleep_gate;
      deep_gate  <= next_deep_gate;
      run_cfg    <= next_run_cfg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_stat <= INT_RESET;
      int_mask <= INT_RESET;
      irq      <= 1'b0;
      mode_q   <= MODE_RUN;
    end else begin
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      irq      <= |(next_int_stat & next_int_mask);
      mode_q   <= mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // Gated units see their clock enable and a hold while off
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      unit_clk_en <= GATE_RESET;  // [R5]
      unit_hold   <= ~GATE_RESET; // [R3]
    end else begin
      unit_clk_en <= sel_gate;    // [R2]
      unit_hold   <= ~sel_gate;   // [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access checker

  assign gi.unit_en = unit_clk_en;
  assign gi.acc_req = acc_req;
  assign gi.acc_bit = acc_bit;
  assign acc_fault  = gi.fault; // [R4]
  assign acc_done   = gi.done;

  dscg_fault_chk u_chk (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .gi      (gi.chk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_reset_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> deep_gate == GATE_RESET && unit_clk_en == GATE_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [R5]
    else $error("gate not cleared after reset");

  property p_deep_write;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == ADDR_W'(OFF_DEEP_GATE)
        |=> deep_gate == ($past(reg_wdata) & GATE_IMPL);
  endproperty
  a_deep_write: assert property (p_deep_write) // [R1]
    else $error("deep gate write not stored");

  property p_deep_read;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_rd && reg_addr == ADDR_W'(OFF_DEEP_GATE)
        |=> reg_rdata == $past(deep_gate);
  endproperty
  a_deep_read: assert property (p_deep_read) // [R1]
    else $error("deep gate read mismatch");

  property p_rsvd_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      reg_rd && hit_any_gate |=> (reg_rdata & ~GATE_IMPL) == '0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // [R12]
    else $error("reserved gate bit read nonzero");

  property p_deep_select;
    @(posedge sys_clk) disable iff (!rst_n)
      auto_gate_on && sys_sleep && sys_deep
        |=> unit_clk_en == $past(deep_gate);
  endproperty
  a_deep_select: assert property (p_deep_select) // [R6]
    else $error("deep-sleep enables not applied");

  property p_sleep_select;
    @(posedge sys_clk) disable iff (!rst_n)
      auto_gate_on && sys_sleep && !sys_deep
        |=> unit_clk_en == $past(sleep_gate);
  endproperty
  a_sleep_select: assert property (p_sleep_select) // [R6]
    else $error("sleep enables not applied");

  property p_run_select;
    @(posedge sys_clk) disable iff (!rst_n)
      !sys_sleep |=> unit_clk_en == $past(run_gate);
  endproperty
  a_run_select: assert property (p_run_select) // [R6]
    else $error("run enables not applied while awake");

  property p_auto_off;
    @(posedge sys_clk) disable iff (!rst_n)
      !auto_gate_on |=> unit_clk_en == $past(run_gate);
  endproperty
  a_auto_off: assert property (p_auto_off) // [R7]
    else $error("sleep enables used without auto gating");

  property p_stat_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      rd_int_stat && events == '0 |=> int_stat == INT_RESET;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status not cleared by read");

  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      unit_hold == ~unit_clk_en;
  endproperty
  a_hold: assert property (p_hold) // [R3]
    else $error("unit hold disagrees with clock enable");

  property p_impl_only;
    @(posedge sys_clk) disable iff (!rst_n)
      (unit_clk_en & ~GATE_IMPL) == '0;
  endproperty
  a_impl_only: assert property (p_impl_only) // [R2]
    else $error("clock enabled on unimplemented bit");

  property p_fault_sticky;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_fault |=> int_stat[INT_FAULT];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) // [R4]
    else $error("fault event lost");

  property p_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      irq == |(int_stat & int_mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level mismatch");

endmodule

`default_nettype wire

/* verif/deep_sleep_clock_gating_bank1_bench.sv */
// Self-checking bench for the deep-sleep clock gating register block.
// Assumes dscg_pkg and dscg_top are compiled first; sys_clk at 200 MHz.
`timescale 1ns/1ps
`default_nettype none

module deep_sleep_clock_gating_bank1_bench;
  import dscg_pkg::*;

  localparam logic [31:0] IMPL    = 32'h010F_1313;
  localparam logic [11:0] GOFF[3] = '{OFF_RUN_GATE, OFF_SLEEP_GATE, 12'h124};

  logic        sys_clk     = 1'b0;
  logic        rst_n       = 1'b0;
  logic [11:0] reg_addr    = 12'h000;
  logic [31:0] reg_wdata   = 32'h0000_0000;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic        sys_sleep   = 1'b0;
  logic        sys_deep    = 1'b0;
  logic        acc_req     = 1'b0;
  logic [4:0]  acc_bit     = 5'h00;
  logic [31:0] reg_rdata;
  logic        acc_fault;
  logic        acc_done;
  logic        irq;
  logic [31:0] unit_clk_en;
  logic [31:0] unit_hold;
  logic [31:0] rd_val;
  logic [31:0] gate[3];
  logic [15:0] lfsr        = 16'hB737;
  int          error_cnt   = 0;
  int          comparisons = 0;

  always #2.5 sys_clk = ~sys_clk;

  dscg_top i_dscg_top (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .sys_sleep   (sys_sleep),
    .sys_deep    (sys_deep),
    .acc_req     (acc_req),
    .acc_bit     (acc_bit),
    .acc_fault   (acc_fault),
    .acc_done    (acc_done),
    .unit_clk_en (unit_clk_en),
    .unit_hold   (unit_hold),
    .irq         (irq)
  );

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Gate word that should reach the units in a given mode
  function automatic logic [31:0] sel_exp(input logic auto_on,
                                          input logic s,
                                          input logic d);
    if (!auto_on || !s) begin
      return gate[0] & IMPL;
    end
    return (d ? gate[2] : gate[1]) & IMPL;
  endfunction

  task automatic rnd32(output logic [31:0] v);
    lfsr = lfsr_step(lfsr);
    v[15:0] = lfsr;
    lfsr = lfsr_step(lfsr);
    v[31:16] = lfsr;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic acc(input logic [4:0] b, input logic f);
    @(posedge sys_clk);
    acc_req <= 1'b1;
    acc_bit <= b;
    @(posedge sys_clk);
    acc_req <= 1'b0;
    #1;
    chk(acc_fault, f);
    chk(acc_done, !f);
  endtask

  task automatic mode(input logic s, input logic d);
    @(posedge sys_clk);
    sys_sleep <= s;
    sys_deep  <= d;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Watchdog

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test;
  end

  //////////////////////////////////////////////////////////////////////////
  // Main sequence

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(unit_clk_en, 32'h0000_0000);
    chk(unit_hold, 32'hFFFF_FFFF);
    rd(12'h124);
    chk(rd_val, 32'h0000_0000);
    wr(12'h124, 32'hFFFF_FFFF);
    rd(12'h124);
    chk(rd_val, IMPL);
    // Walking one across the deep-sleep gate word
    for (int i = 0; i < 32; i++) begin
      wr(12'h124, 32'h1 << i);
      rd(12'h124);
      chk(rd_val, IMPL & (32'h1 << i));
    end
    // Random contents for run, sleep and deep-sleep words
    for (int k = 0; k < 3; k++) begin
      rnd32(gate[k]);
      wr(GOFF[k], gate[k]);
      rd(GOFF[k]);
      chk(rd_val, gate[k] & IMPL);
    end
    // Selection with automatic gating off, then on
    for (int a = 0; a < 2; a++) begin
      wr(OFF_RUN_CFG, a[0] ? 32'h0800_0000 : 32'h0000_0000);
      for (int m = 0; m < 3; m++) begin
        mode(m != 0, m == 2);
        chk(unit_clk_en, sel_exp(a[0], m != 0, m == 2));
        chk(unit_hold, ~sel_exp(a[0], m != 0, m == 2));
      end
    end
    // Every unit index while in deep-sleep
    for (int i = 0; i < 32; i++) begin
      acc(i[4:0], !(gate[2][i] && IMPL[i]));
    end
    // Fault interrupt: raised, cleared by read, then masked
    wr(OFF_INT_MASK, 32'h0000_0001);
    rd(OFF_INT_STAT);
    chk(irq, 1'b0);
    acc(5'd2, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(irq, 1'b1);
    rd(OFF_INT_STAT);
    chk(rd_val & 32'h1, 32'h1);
    chk(irq, 1'b0);
    wr(OFF_INT_MASK, 32'h0000_0000);
    acc(5'd2, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    // Status events: reserved-bit write, entering sleep and deep-sleep
    rd(OFF_INT_STAT);
    wr(12'h124, 32'h8000_0000);
    rd(OFF_INT_STAT);
    chk(rd_val, 32'h0000_0008);
    chk(unit_clk_en, 32'h0000_0000);
    mode(1'b1, 1'b0);
    mode(1'b1, 1'b1);
    rd(OFF_INT_STAT);
    chk(rd_val, 32'h0000_0006);
    // Unmapped place
    wr(12'h300, 32'hFFFF_FFFF);
    rd(12'h300);
    chk(rd_val, 32'h0000_0000);
    // Reset in mid-run
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(12'h124);
    chk(rd_val, 32'h0000_0000);
    chk(unit_clk_en, 32'h0000_0000);
    chk(unit_hold, 32'hFFFF_FFFF);
    end_of_test;
  end

endmodule

`default_nettype wire
